// ---- common/gdc_pkg.sv ----
// Package for the gate driver configuration register bank.
// Assumes a 10 MHz system clock and a decoded frame from an SPI front end.
`default_nettype none
package gdc_pkg;

  // ****************************************
  // Register offsets and bank indices
  // ****************************************
  localparam logic [4:0] GC1_OFS = 5'h00;
  localparam logic [4:0] GC2_OFS = 5'h01;
  localparam logic [4:0] VDS_LO_OFS = 5'h02;
  localparam logic [4:0] VDS_HI_OFS = 5'h03;
  localparam logic [4:0] PAIR_MAP_OFS = 5'h04;
  localparam logic [4:0] TIMES_OFS = 5'h05;
  localparam int NUM_REGS = 7;
  localparam logic [2:0] IDX_GC1 = 3'h0;
  localparam logic [2:0] IDX_GC2 = 3'h1;
  localparam logic [2:0] IDX_ACT = 3'h5;
  localparam logic [2:0] IDX_FW = 3'h6;
  localparam logic [2:0] IDX_NONE = 3'h7;

  // ****************************************
  // Reset values and writable masks
  // ****************************************
  localparam logic [15:0] GC1_RST = 16'h0026;
  localparam logic [15:0] GC2_RST = 16'h4180;
  localparam logic [15:0] VDS_RST = 16'h0249;
  localparam logic [15:0] PAIR_MAP_RST = 16'h0000;
  localparam logic [15:0] TIMES_RST = 16'h4924;
  localparam logic [15:0] GC1_WMASK = 16'hFFAF;
  localparam logic [15:0] FULL_WMASK = 16'hFFFF;
  localparam logic [15:0] TIMES_WMASK = 16'h7FFF;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int GC1_KICK = 0;
  localparam int GC1_WIN = 1;
  localparam int GC1_OC_ON = 2;
  localparam int GC1_STEP = 3;
  localparam int GC1_SPREAD = 5;
  localparam int GC1_UNLOCK = 7;
  localparam int GC1_BANK = 9;
  localparam int GC1_DIR_A = 12;
  localparam int GC1_DIR_B = 15;
  localparam int GC2_OCL_A = 0;
  localparam int GC2_OCL_B = 2;
  localparam int GC2_DFILT = 4;
  localparam int GC2_STAGE = 6;
  localparam int GC2_UVTH = 7;
  localparam int GC2_DMASK = 8;
  localparam int GC2_WDOFF = 9;
  localparam int GC2_HOLD = 10;
  localparam int GC2_ADAPT = 11;
  localparam int GC2_ADAPT_FILT = 13;
  localparam int GC2_PASS = 14;
  localparam int GC2_POFF = 15;
  localparam int VDS_FLD_W = 3;
  localparam int TIME_FLD_W = 3;
  localparam int NUM_TIMES = 5;

  // ****************************************
  // Encodings and timing
  // ****************************************
  localparam logic [1:0] ADAPT_ALL_OFF = 2'b00;
  localparam logic [1:0] ADAPT_PREDIS_ONLY = 2'b01;
  localparam logic [3:0] HOLD_STEP_LOW = 4'h8;
  localparam logic [3:0] HOLD_STEP_HIGH = 4'hC;
  localparam int CLK_MHZ = 10;
  localparam int WD_SHORT_MS = 50;
  localparam int WD_LONG_MS = 200;
  localparam int WD_SHORT_CYC = WD_SHORT_MS * 1000 * CLK_MHZ;
  localparam int WD_LONG_CYC = WD_LONG_MS * 1000 * CLK_MHZ;
  localparam int GUARD_NS [8] = '{375, 625, 1000, 1500, 2000, 3000, 4000, 16000};
  localparam int BLANK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 8000};
  localparam int DFILT_NS [4] = '{500, 1000, 2000, 3000};

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic write;
    logic [4:0] addr;
    logic [15:0] wdata;
  } gdc_frame_s;

  typedef struct packed {
    logic adapt_on;
    logic precharge_on;
    logic predischarge_on;
    logic filter_on;
    logic step_two;
  } gdc_adapt_s;

endpackage : gdc_pkg

`default_nettype wire

// ---- src/gdc_regs.sv ----
// Configuration register bank of the half-bridge gate driver.
// Frames arrive already decoded, one pulse per completed frame, on SYS_CLK.
`timescale 1ns/1ps
`default_nettype none

module gdc_regs
  import gdc_pkg::*;
#(
  parameter int WD_SHORT = WD_SHORT_CYC,
  parameter int WD_LONG = WD_LONG_CYC,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Decoded frame from the serial front end
  input wire gdc_frame_s FRAME,
  output logic RVALID,
  output logic [15:0] RDATA,
  // Fault inputs from the PWM channels
  input wire logic [2:0] DELAY_ERR,
  input wire logic [2:0] PWM_ON,
  output logic DELAY_FLAG,
  // Watchdog
  output logic WDOG_ENABLED,
  output logic WDOG_TIMEOUT,
  // Pump and general settings
  output logic PUMP_SPREAD_ON,
  output logic OC_SHUTDOWN_ON,
  output logic POSTCHARGE_OFF,
  output logic BRIDGE_PASSIVE,
  output gdc_adapt_s ADAPT_CFG,
  output logic [3:0] HOLD_STEP,
  output logic PUMP_UV_HIGH,
  output logic PUMP_STAGE_AUTO,
  output logic [CNT_W-1:0] DRAIN_FILTER_CYC,
  // Current sense
  output logic [1:0] SENSE_BIDIR,
  output logic [1:0] OC_LEVEL_A,
  output logic [1:0] OC_LEVEL_B,
  // Per bridge settings
  output logic [23:0] DRAIN_THRESH,
  output logic [15:0] PAIR_SEL,
  // Guard and blank durations, active then freewheeling set
  output logic [NUM_TIMES*CNT_W-1:0] ACT_TIME_CYC,
  output logic [NUM_TIMES*CNT_W-1:0] FW_TIME_CYC
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (WD_SHORT < 1 || WD_LONG < 1 || WD_LONG >= (1 << 22)) begin : g_bad_wd
    $error("watchdog period outside counter range");
  end
  if (CNT_W < 8 || CNT_W > 16) begin : g_bad_cnt
    $error("count width must hold 160 cycles");
  end

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic [2:0] reg_index(input logic [4:0] addr, input logic bank);
    logic [2:0] idx;
    idx = IDX_NONE;
    if (addr <= PAIR_MAP_OFS) begin
      idx = addr[2:0];
    end else if (addr == TIMES_OFS) begin
      idx = bank ? IDX_FW : IDX_ACT;
    end
    return idx;
  endfunction

  // Round to nearest cycle so the error stays within one period
  function automatic logic [CNT_W-1:0] ns_to_cyc(input int ns);
    int cyc;
    cyc = (ns * CLK_MHZ + 500) / 1000;
    if (cyc < 1) begin
      cyc = 1;
    end
    return CNT_W'(cyc);
  endfunction

  function automatic logic [CNT_W-1:0] time_cyc(input logic [2:0] code, input logic blank);
    logic [CNT_W-1:0] c;
    c = blank ? ns_to_cyc(BLANK_NS[code]) : ns_to_cyc(GUARD_NS[code]);
    return c;
  endfunction

  function automatic logic [15:0] reset_of(input int i);
    logic [15:0] v;
    v = TIMES_RST;
    if (i == 0) begin
      v = GC1_RST;
    end else if (i == 1) begin
      v = GC2_RST;
    end else if (i == 2 || i == 3) begin
      v = VDS_RST;
    end else if (i == 4) begin
      v = PAIR_MAP_RST;
    end
    return v;
  endfunction

  function automatic logic [15:0] wmask_of(input int i);
    logic [15:0] m;
    m = FULL_WMASK;
    if (i == 0) begin
      m = GC1_WMASK;
    end else if (i >= 5) begin
      m = TIMES_WMASK;
    end
    return m;
  endfunction

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] regs_q [NUM_REGS];
  logic [2:0] frame_idx;
  logic wr_en;
  logic unlock_armed_q;
  logic [15:0] gc1;
  logic [15:0] gc2;
  logic wdoff_d;

  assign frame_idx = reg_index(FRAME.addr, regs_q[IDX_GC1][GC1_BANK]);
  assign wr_en = FRAME.valid && FRAME.write;
  assign gc1 = regs_q[IDX_GC1];
  assign gc2 = regs_q[IDX_GC2];
  // Setting needs the arm from the previous frame; clearing never does
  assign wdoff_d = FRAME.wdata[GC2_WDOFF] && (unlock_armed_q || gc2[GC2_WDOFF]);

  for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
    // Fixed per slot, so the reset branch loads constants only
    localparam logic [15:0] RST_V = reset_of(i);
    localparam logic [15:0] WMASK = wmask_of(i);
    logic [15:0] wval;
    always_comb begin
      wval = FRAME.wdata;
      if (i == 1) begin
        wval[GC2_WDOFF] = wdoff_d;
      end
    end
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        regs_q[i] <= RST_V;
      end else if (wr_en && frame_idx == 3'(i)) begin
        regs_q[i] <= (regs_q[i] & ~WMASK) | (wval & WMASK);
      end
    end
  end

  // Any frame consumes the arm, so it covers the next frame only
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      unlock_armed_q <= 1'b0;
    end else if (FRAME.valid) begin
      unlock_armed_q <= wr_en && frame_idx == IDX_GC1 && FRAME.wdata[GC1_UNLOCK];
    end
  end

  // ****************************************
  // In-frame read answer
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      RVALID <= 1'b0;
      RDATA <= 16'h0000;
    end else begin
      RVALID <= FRAME.valid;
      if (FRAME.valid) begin
        // Pre-write content; unmapped offsets answer zero
        RDATA <= (frame_idx == IDX_NONE) ? 16'h0000 : regs_q[frame_idx];
      end
    end
  end

  // ****************************************
  // Watchdog window
  // ****************************************
  logic [21:0] wd_cnt_q;
  logic kick;
  logic [21:0] wd_limit;

  // A kick is a write that inverts the trigger bit
  assign kick = wr_en && frame_idx == IDX_GC1 && (FRAME.wdata[GC1_KICK] != gc1[GC1_KICK]);
  assign wd_limit = gc1[GC1_WIN] ? 22'(WD_LONG) : 22'(WD_SHORT);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wd_cnt_q <= 22'h00_0000;
      WDOG_TIMEOUT <= 1'b0;
    end else begin
      WDOG_TIMEOUT <= 1'b0;
      if (gc2[GC2_WDOFF] || kick) begin
        wd_cnt_q <= 22'h00_0000;
      end else if (wd_cnt_q >= wd_limit - 22'd1) begin
        wd_cnt_q <= 22'h00_0000;
        WDOG_TIMEOUT <= 1'b1;
      end else begin
        wd_cnt_q <= wd_cnt_q + 22'd1;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      WDOG_ENABLED <= 1'b0;
    end else begin
      WDOG_ENABLED <= !gc2[GC2_WDOFF];
    end
  end

  // ****************************************
  // Delay error contribution to the global flag
  // ****************************************
  logic [2:0] derr_s1_q;
  logic [2:0] derr_s2_q;

  // Error lines come from the analog side, so synchronise first
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      derr_s1_q <= 3'h0;
      derr_s2_q <= 3'h0;
      DELAY_FLAG <= 1'b0;
    end else begin
      derr_s1_q <= DELAY_ERR;
      derr_s2_q <= derr_s1_q;
      DELAY_FLAG <= |(derr_s2_q & PWM_ON) && !gc2[GC2_DMASK];
    end
  end

  // ****************************************
  // Charge pump settings
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PUMP_SPREAD_ON <= 1'b0;
      PUMP_UV_HIGH <= 1'b0;
      PUMP_STAGE_AUTO <= 1'b0;
    end else begin
      PUMP_SPREAD_ON <= gc1[GC1_SPREAD];
      PUMP_UV_HIGH <= gc2[GC2_UVTH];
      PUMP_STAGE_AUTO <= gc2[GC2_STAGE];
    end
  end

  // ****************************************
  // Bridge drive settings
  // ****************************************
  // Passive from reset until GC2 clears its pass bit (set in GC2_RST), so no gate is driven early
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      POSTCHARGE_OFF <= 1'b0;
      BRIDGE_PASSIVE <= 1'b1;
      HOLD_STEP <= HOLD_STEP_LOW;
    end else begin
      POSTCHARGE_OFF <= gc2[GC2_POFF];
      BRIDGE_PASSIVE <= gc2[GC2_PASS];
      HOLD_STEP <= gc2[GC2_HOLD] ? HOLD_STEP_HIGH : HOLD_STEP_LOW;
    end
  end

  // ****************************************
  // Adaptive gate control
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ADAPT_CFG <= '0;
    end else begin
      ADAPT_CFG.adapt_on <= gc2[GC2_ADAPT+1];
      ADAPT_CFG.precharge_on <= gc2[GC2_ADAPT+1];
      ADAPT_CFG.predischarge_on <= gc2[GC2_ADAPT+:2] != ADAPT_ALL_OFF;
      ADAPT_CFG.filter_on <= gc2[GC2_ADAPT_FILT];
      ADAPT_CFG.step_two <= gc1[GC1_STEP];
    end
  end

  // ****************************************
  // Current sense and overcurrent
  // ****************************************
  // Level codes pass with their direction bit; the comparator reads both
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      OC_SHUTDOWN_ON <= 1'b0;
      SENSE_BIDIR <= 2'b00;
      OC_LEVEL_A <= 2'b00;
      OC_LEVEL_B <= 2'b00;
    end else begin
      OC_SHUTDOWN_ON <= gc1[GC1_OC_ON];
      SENSE_BIDIR <= {gc1[GC1_DIR_B], gc1[GC1_DIR_A]};
      OC_LEVEL_A <= gc2[GC2_OCL_A+:2];
      OC_LEVEL_B <= gc2[GC2_OCL_B+:2];
    end
  end

  // ****************************************
  // Drain monitor and timing pair map
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      DRAIN_FILTER_CYC <= '0;
      DRAIN_THRESH <= '0;
    end else begin
      DRAIN_FILTER_CYC <= ns_to_cyc(DFILT_NS[gc2[GC2_DFILT+:2]]);
      DRAIN_THRESH <= {regs_q[3][11:0], regs_q[2][11:0]};
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      PAIR_SEL <= '0;
    end else begin
      PAIR_SEL <= regs_q[4];
    end
  end

  // Even fields are guard times, odd fields blank times
  for (genvar t = 0; t < NUM_TIMES; t++) begin : g_time
    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        ACT_TIME_CYC[t*CNT_W+:CNT_W] <= '0;
        FW_TIME_CYC[t*CNT_W+:CNT_W] <= '0;
      end else begin
        ACT_TIME_CYC[t*CNT_W+:CNT_W] <=
          time_cyc(regs_q[IDX_ACT][t*TIME_FLD_W+:TIME_FLD_W], t % 2 == 1);
        FW_TIME_CYC[t*CNT_W+:CNT_W] <=
          time_cyc(regs_q[IDX_FW][t*TIME_FLD_W+:TIME_FLD_W], t % 2 == 1);
      end
    end
  end

endmodule // gdc_regs

`default_nettype wire

// ---- verification/gdc_host.sv ----
// Host model issuing decoded frames to the register bank.
// Assumes frames are taken on the rising edge of SYS_CLK.
`timescale 1ns/1ps
`default_nettype none
module gdc_host
  import gdc_pkg::*;
(
  // Clock and answer
  input wire logic SYS_CLK,
  input wire logic RVALID,
  input wire logic [15:0] RDATA,
  // Frame
  output var gdc_frame_s FRAME
);
  logic [15:0] gc1_q = 16'h0026;
  initial FRAME = '0;
  // *****
  // Frame access
  // *****
  task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d,
                      output logic [15:0] rd, output logic ok);
    @(posedge SYS_CLK);
    #1 FRAME = '{1'b1, w, a, d};
    @(posedge SYS_CLK);
    // Released lines show inverted data, not the last value
    #1 FRAME = '{1'b0, ~w, ~a, ~d};
    ok = RVALID;
    rd = RDATA;
    if (w && a == GC1_OFS) begin
      gc1_q = d;
    end
    @(posedge SYS_CLK);
    #1;
  endtask
  // Toggle kick bit, keep the other control bits
  task automatic kick();
    logic [15:0] rd;
    logic ok;
    xfer(1'b1, GC1_OFS, {gc1_q[15:1], ~gc1_q[0]}, rd, ok);
  endtask
endmodule // gdc_host
`default_nettype wire

// ---- verification/gdc_regs_sva.sv ----
// Port checker for the register bank.
// Bound onto gdc_regs; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module gdc_regs_sva
  import gdc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Frames and outputs
  input wire gdc_frame_s FRAME,
  input wire logic [15:0] RDATA,
  input wire logic WDOG_ENABLED,
  input wire logic BRIDGE_PASSIVE,
  input wire gdc_adapt_s ADAPT_CFG,
  input wire logic [3:0] HOLD_STEP
);
  // *****
  // Unlock model
  // *****
  logic arm_q;
  logic off_q;
  wire logic wr2;
  assign wr2 = FRAME.valid && FRAME.write && FRAME.addr == GC2_OFS;
  // Any frame consumes the arm
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      arm_q <= 1'b0;
    end else if (FRAME.valid) begin
      arm_q <= FRAME.write && FRAME.addr == GC1_OFS && FRAME.wdata[GC1_UNLOCK];
    end
  end
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      off_q <= 1'b0;
    end else if (wr2) begin
      off_q <= FRAME.wdata[GC2_WDOFF] && (arm_q || off_q);
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // *****
  // Properties
  // *****
  a_gc1_reserved: assert property (FRAME.valid && FRAME.addr == GC1_OFS |=>
    !RDATA[6] && !RDATA[4]) else $error("Reserved control bits read as one");
  a_times_top_zero: assert property (FRAME.valid && FRAME.addr == TIMES_OFS |=>
    !RDATA[15]) else $error("Timing top bit read as one");
  a_unmapped_zero: assert property (FRAME.valid && FRAME.addr > TIMES_OFS |=>
    RDATA == 16'h0000) else $error("Unmapped offset read nonzero");
  a_hold_follow: assert property (wr2 |-> ##2 HOLD_STEP ==
    ($past(FRAME.wdata[GC2_HOLD], 2) ? HOLD_STEP_HIGH : HOLD_STEP_LOW))
    else $error("Hold step does not follow its bit");
  a_passive_follow: assert property (wr2 |-> ##2
    BRIDGE_PASSIVE == $past(FRAME.wdata[GC2_PASS], 2)) else $error("Passive bit lost");
  a_adapt_decode: assert property (wr2 |-> ##2 ADAPT_CFG.adapt_on ==
    $past(FRAME.wdata[GC2_ADAPT+1], 2) && ADAPT_CFG.predischarge_on ==
    ($past(FRAME.wdata[GC2_ADAPT+:2], 2) != ADAPT_ALL_OFF))
    else $error("Adaptive gate decode wrong");
  a_wd_follow: assert property ($past(RSTN) |-> WDOG_ENABLED == !$past(off_q))
    else $error("Watchdog enable differs from unlock model");
  a_wd_reenable: assert property (wr2 && !FRAME.wdata[GC2_WDOFF] |-> ##2
    WDOG_ENABLED) else $error("Watchdog not re-enabled");
  c_unlocked_off: cover property (wr2 && arm_q && FRAME.wdata[GC2_WDOFF]);
  c_time_write: cover property (FRAME.valid && FRAME.write && FRAME.addr == TIMES_OFS);
  c_unmapped: cover property (FRAME.valid && FRAME.addr > TIMES_OFS);
endmodule // gdc_regs_sva
bind gdc_regs gdc_regs_sva gdc_regs_sva_inst (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .FRAME(FRAME),
  .RDATA(RDATA), .WDOG_ENABLED(WDOG_ENABLED), .BRIDGE_PASSIVE(BRIDGE_PASSIVE),
  .ADAPT_CFG(ADAPT_CFG), .HOLD_STEP(HOLD_STEP));
`default_nettype wire

// ---- verification/tb_top.sv ----
// Self-checking bench for the register bank.
// Assumes gdc_host drives frames and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import gdc_pkg::*;
;
  // *****
  // Signals
  // *****
  localparam int WS = 50;
  localparam int WL = 200;
  logic SYS_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic [2:0] DELAY_ERR = 3'h0;
  logic [2:0] PWM_ON = 3'h0;
  gdc_frame_s FRAME;
  logic RVALID, DELAY_FLAG, WDOG_ENABLED, WDOG_TIMEOUT, PUMP_SPREAD_ON, OC_SHUTDOWN_ON;
  logic POSTCHARGE_OFF, BRIDGE_PASSIVE, PUMP_UV_HIGH, PUMP_STAGE_AUTO;
  logic [15:0] RDATA, PAIR_SEL;
  gdc_adapt_s ADAPT_CFG;
  logic [3:0] HOLD_STEP;
  logic [7:0] DRAIN_FILTER_CYC;
  logic [1:0] SENSE_BIDIR, OC_LEVEL_A, OC_LEVEL_B;
  logic [23:0] DRAIN_THRESH;
  logic [39:0] ACT_TIME_CYC, FW_TIME_CYC;
  int failures = 0;
  int samples_checked = 0;
  int to_cnt = 0;
  logic [15:0] rst_t [8] = '{16'h0026, 16'h4180, 16'h0249, 16'h0249, 16'h0000, 16'h4924,
                            16'h0000, 16'h0000};
  always #50 SYS_CLK = ~SYS_CLK;
  // Mid-cycle, where the one-cycle pulse is settled
  always @(negedge SYS_CLK) if (WDOG_TIMEOUT === 1'b1) to_cnt++;
  gdc_regs #(.WD_SHORT(WS), .WD_LONG(WL), .CNT_W(8)) gdc_regs_inst (.SYS_CLK(SYS_CLK),
    .RSTN(RSTN), .FRAME(FRAME), .RVALID(RVALID), .RDATA(RDATA), .DELAY_ERR(DELAY_ERR),
    .PWM_ON(PWM_ON), .DELAY_FLAG(DELAY_FLAG), .WDOG_ENABLED(WDOG_ENABLED),
    .WDOG_TIMEOUT(WDOG_TIMEOUT), .PUMP_SPREAD_ON(PUMP_SPREAD_ON),
    .OC_SHUTDOWN_ON(OC_SHUTDOWN_ON), .POSTCHARGE_OFF(POSTCHARGE_OFF),
    .BRIDGE_PASSIVE(BRIDGE_PASSIVE), .ADAPT_CFG(ADAPT_CFG), .HOLD_STEP(HOLD_STEP),
    .PUMP_UV_HIGH(PUMP_UV_HIGH), .PUMP_STAGE_AUTO(PUMP_STAGE_AUTO),
    .DRAIN_FILTER_CYC(DRAIN_FILTER_CYC), .SENSE_BIDIR(SENSE_BIDIR), .OC_LEVEL_A(OC_LEVEL_A),
    .OC_LEVEL_B(OC_LEVEL_B), .DRAIN_THRESH(DRAIN_THRESH), .PAIR_SEL(PAIR_SEL),
    .ACT_TIME_CYC(ACT_TIME_CYC), .FW_TIME_CYC(FW_TIME_CYC));
  gdc_host gdc_host_inst (.SYS_CLK(SYS_CLK), .RVALID(RVALID), .RDATA(RDATA), .FRAME(FRAME));
  // *****
  // Tasks
  // *****
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rw(input logic w, input logic [4:0] a, input logic [15:0] d,
                    input logic [15:0] e);
    logic [15:0] r;
    logic ok;
    gdc_host_inst.xfer(w, a, d, r, ok);
    chk(r, e);
    chk(ok, 1'b1);
  endtask
  // Cycles up to the next timeout pulse, bounded
  task automatic wd_wait(input int lim, output int n);
    n = 0;
    do begin
      @(posedge SYS_CLK);
      #1 n++;
      if (n > lim) begin
        failures++;
        tally_and_finish();
      end
    end while (WDOG_TIMEOUT !== 1'b1);
  endtask
  // *****
  // Sequence
  // *****
  initial begin
    int n;
    logic [15:0] p;
    logic [1:0] k;
    logic [7:0] g;
    logic [7:0] b;
    repeat (5) @(posedge SYS_CLK);
    #1 RSTN = 1'b1;
    for (int a = 0; a < 8; a++) begin
      rw(1'b0, 5'(a), 16'h0000, rst_t[a]);
    end
    chk({PUMP_SPREAD_ON, OC_SHUTDOWN_ON, BRIDGE_PASSIVE, WDOG_ENABLED, POSTCHARGE_OFF,
         PUMP_STAGE_AUTO, PUMP_UV_HIGH}, 7'h79);
    chk({ADAPT_CFG, HOLD_STEP, DRAIN_FILTER_CYC}, {5'h00, 4'h8, 8'h05});
    chk(ACT_TIME_CYC, {5{8'h14}});
    rw(1'b1, GC1_OFS, 16'hFDFF, 16'h0026);
    rw(1'b0, GC1_OFS, 16'h0000, 16'hFDAF);
    chk({SENSE_BIDIR, PUMP_SPREAD_ON, OC_SHUTDOWN_ON, ADAPT_CFG.step_two}, 5'h1F);
    rw(1'b1, GC1_OFS, 16'h0000, 16'hFDAF);
    chk({SENSE_BIDIR, PUMP_SPREAD_ON, OC_SHUTDOWN_ON, ADAPT_CFG.step_two}, 5'h00);
    rw(1'b1, GC2_OFS, 16'h0200, 16'h4180);
    rw(1'b1, GC1_OFS, 16'h0080, 16'h0000);
    rw(1'b0, GC1_OFS, 16'h0000, 16'h0080);
    rw(1'b1, GC2_OFS, 16'h0200, 16'h0000);
    chk(WDOG_ENABLED, 1'b1);
    rw(1'b1, GC1_OFS, 16'h0080, 16'h0080);
    rw(1'b1, GC2_OFS, 16'h0200, 16'h0000);
    chk(WDOG_ENABLED, 1'b0);
    rw(1'b1, GC2_OFS, 16'h0000, 16'h0200);
    chk(WDOG_ENABLED, 1'b1);
    p = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      rw(1'b1, GC2_OFS, {k[0], k[1], k[0], k, k[0], 1'b0, k[1], k[0], k[0], k, k, k}, p);
      p = {k[0], k[1], k[0], k, k[0], 1'b0, k[1], k[0], k[0], k, k, k};
      chk(ADAPT_CFG, {k[1], k[1], k != 2'b00, k[0], 1'b0});
      chk(HOLD_STEP, k[0] ? 4'hC : 4'h8);
      chk(DRAIN_FILTER_CYC, 8'(DFILT_NS[i] / 100));
      chk({POSTCHARGE_OFF, BRIDGE_PASSIVE, PUMP_UV_HIGH, PUMP_STAGE_AUTO, OC_LEVEL_B,
           OC_LEVEL_A}, {k[0], k[1], k[0], k[0], k, k});
    end
    DELAY_ERR = 3'h1;
    PWM_ON = 3'h1;
    repeat (4) @(posedge SYS_CLK);
    #1 chk(DELAY_FLAG, 1'b0);
    rw(1'b1, GC2_OFS, 16'h0000, p);
    repeat (3) @(posedge SYS_CLK);
    #1 chk(DELAY_FLAG, 1'b1);
    rw(1'b1, VDS_LO_OFS, 16'hFFFF, 16'h0249);
    rw(1'b1, VDS_HI_OFS, 16'h0A5C, 16'h0249);
    chk(DRAIN_THRESH, 24'hA5_CFFF);
    rw(1'b1, PAIR_MAP_OFS, 16'hE41B, 16'h0000);
    chk(PAIR_SEL, 16'hE41B);
    p = 16'h4924;
    for (int i = 0; i < 8; i++) begin
      g = 8'((GUARD_NS[i] + 50) / 100);
      b = 8'((BLANK_NS[i] + 50) / 100);
      rw(1'b1, TIMES_OFS, {1'b1, {5{3'(i)}}}, p);
      p = {1'b0, {5{3'(i)}}};
      chk(ACT_TIME_CYC, {g, b, g, b, g});
    end
    chk(FW_TIME_CYC, {5{8'h14}});
    rw(1'b1, GC1_OFS, 16'h0200, 16'h0080);
    rw(1'b1, TIMES_OFS, 16'h0000, 16'h4924);
    chk(FW_TIME_CYC, 40'h04_0604_0604);
    rw(1'b1, GC1_OFS, 16'h0000, 16'h0200);
    rw(1'b0, TIMES_OFS, 16'h0000, 16'h7FFF);
    wd_wait(WL + 10, n);
    wd_wait(WS + 10, n);
    chk(n >= WS - 1 && n <= WS + 1, 1'b1);
    rw(1'b1, GC1_OFS, 16'h0002, 16'h0000);
    wd_wait(WL + 10, n);
    wd_wait(WL + 10, n);
    chk(n >= WL - 1 && n <= WL + 1, 1'b1);
    // Let the pulse just seen be counted before taking the base
    @(posedge SYS_CLK);
    #1 n = to_cnt;
    repeat (8) begin
      repeat (30) @(posedge SYS_CLK);
      gdc_host_inst.kick();
    end
    chk(to_cnt, n);
    RSTN = 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1 RSTN = 1'b1;
    rw(1'b0, GC2_OFS, 16'h0000, 16'h4180);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
